// file: ame_msg_mem.sv
// received-message byte store with registered read port
`timescale 1ns/1ps
`default_nettype none

module ame_msg_mem #(
  parameter int DATA_W = 8,
  parameter int DEPTH  = 32,
  parameter int AW     = 5
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_we,
  input  wire logic [AW-1:0]     i_waddr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic [AW-1:0]     i_raddr,
  output logic      [DATA_W-1:0] o_rdata
);

  logic [DATA_W-1:0] mem_r [DEPTH];

  if ((1 << AW) < DEPTH) begin : g_bad_aw
    $error("ame_msg_mem: AW too small for DEPTH");
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_we) begin
      mem_r[i_waddr] <= i_wdata;
    end
    o_rdata <= mem_r[i_raddr];
  end

endmodule : ame_msg_mem

`default_nettype wire

// file: ame_framer.sv
// authentication message framer and parser, with its constants package
`timescale 1ns/1ps
`default_nettype none

package ame_pkg;
  // ==========================================================
  // message and element codes
  localparam logic [7:0] MT_REQUEST           = 8'h40;
  localparam logic [7:0] MT_REPLY             = 8'h41;
  localparam logic [7:0] ELEMENT_ID_CHALLENGE = 8'h0C;
  localparam logic [7:0] ELEMENT_ID_RESPONSE  = 8'h0D;
  localparam logic [7:0] ELEMENT_ID_SEED      = 8'h0E;
  localparam logic [7:0] ELEMENT_ID_SELECTOR  = 8'h0A;
  // ==========================================================
  // element sizes in octets, identifier and length octet included
  localparam int HDR_OCTETS    = 2;
  localparam int LEN_CHALLENGE = 10;
  localparam int LEN_RESPONSE  = 6;
  localparam int LEN_SEED      = 10;
  localparam int LEN_SELECTOR  = 5;
  localparam logic [7:0] LI_CHALLENGE = 8'(LEN_CHALLENGE - HDR_OCTETS);
  localparam logic [7:0] LI_RESPONSE  = 8'(LEN_RESPONSE - HDR_OCTETS);
  localparam logic [7:0] LI_SEED      = 8'(LEN_SEED - HDR_OCTETS);
  localparam logic [7:0] LI_SELECTOR  = 8'(LEN_SELECTOR - HDR_OCTETS);
  localparam int CHAL_BITS = 64;
  localparam int RESP_BITS = 32;
  localparam int SEED_BITS = 64;
  localparam int SEL_BITS  = 24;
  // ==========================================================
  // frame sizes in octets
  localparam int         FRAME_OCTETS    = 26;
  localparam int         FRAME_BITS      = FRAME_OCTETS * 8;
  localparam logic [4:0] FRM_REQ_FIXED   = 5'h1A;
  localparam logic [4:0] FRM_REQ_PORT    = 5'h10;
  localparam logic [4:0] FRM_REQ_PORT_KA = 5'h16;
  localparam logic [4:0] FRM_REP_PORT    = 5'h07;
  localparam logic [4:0] FRM_REP_FIXED   = 5'h11;
  localparam int         PARSE_BOUND     = 80;
  // ==========================================================
  typedef enum logic [5:0] {
    PS_IDLE = 6'h01,
    PS_TYPE = 6'h02,
    PS_ID   = 6'h04,
    PS_LEN  = 6'h08,
    PS_BODY = 6'h10,
    PS_EVAL = 6'h20
  } ame_pstate_type;
endpackage : ame_pkg

// How it works
// - message type octet is 0x40 for request, 0x41 for reply, top bit zero
// - portable request carries selector and challenge holding portable challenge
// - fixed request carries selector, session seed and fixed challenge
// - portable reply holds its answer; fixed reply holds seed plus fixed answer
// - element identifiers: challenge 0x0C, response 0x0D, session seed 0x0E
// - key/algorithm selector element uses identifier 0x0A
// - element sizes: challenge 10, response 6, seed 10, selector 5 octets
// - value msb goes to bit 8 of octet 3, right after length octet
// - value lsb goes to bit 1 of last octet: 10, 6 or 5
// - fixed unit sends request with latched expectation, then checks portable reply
// - fixed unit drops call when portable answer differs from expected
// - portable unit sends challenge request, then checks fixed reply
// - portable unit drops call when fixed answer differs from expected
// - response in portable request only for key allocation exchanges
// - extra unrelated elements are accepted without error
module ame_framer
  import ame_pkg::*;
#(
  parameter int MEM_DEPTH = 32
) (
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_rstn,
  input  wire logic                 i_role_fixed,
  input  wire logic                 i_req_go,
  input  wire logic                 i_reply_go,
  input  wire logic                 i_key_alloc,
  input  wire logic [CHAL_BITS-1:0] i_challenge,
  input  wire logic [SEED_BITS-1:0] i_seed,
  input  wire logic [SEL_BITS-1:0]  i_selector,
  input  wire logic [RESP_BITS-1:0] i_expected,
  input  wire logic [RESP_BITS-1:0] i_own_answer,
  input  wire logic                 i_tx_ready,
  output logic                      o_tx_valid,
  output logic      [7:0]           o_tx_data,
  output logic                      o_tx_last,
  input  wire logic                 i_rx_valid,
  input  wire logic [7:0]           i_rx_data,
  input  wire logic                 i_rx_last,
  output logic                      o_rx_ready,
  output logic                      o_req_rcvd,
  output logic                      o_rx_key_alloc,
  output logic      [CHAL_BITS-1:0] o_rx_challenge,
  output logic      [SEED_BITS-1:0] o_rx_seed,
  output logic      [RESP_BITS-1:0] o_rx_answer,
  output logic      [SEL_BITS-1:0]  o_rx_selector,
  output logic                      o_auth_pass,
  output logic                      o_call_drop,
  output logic                      o_msg_err,
  output logic                      o_auth_pending
);

  localparam int AW = $clog2(MEM_DEPTH);
  localparam logic [AW:0] DEPTH_CNT = (AW + 1)'(MEM_DEPTH);
  localparam logic [AW:0] ONE_CNT   = (AW + 1)'(1);

  if (MEM_DEPTH < 8 || MEM_DEPTH > 256) begin : g_bad_depth
    $error("ame_framer: MEM_DEPTH must lie in 8..256");
  end

  // ==========================================================
  // element builders, value sent msb first
  function automatic logic [8*LEN_CHALLENGE-1:0] el_challenge(input logic [CHAL_BITS-1:0] v);
    return {ELEMENT_ID_CHALLENGE, LI_CHALLENGE, v};
  endfunction : el_challenge

  function automatic logic [8*LEN_SEED-1:0] el_seed(input logic [SEED_BITS-1:0] v);
    return {ELEMENT_ID_SEED, LI_SEED, v};
  endfunction : el_seed

  function automatic logic [8*LEN_RESPONSE-1:0] el_response(input logic [RESP_BITS-1:0] v);
    return {ELEMENT_ID_RESPONSE, LI_RESPONSE, v};
  endfunction : el_response

  function automatic logic [8*LEN_SELECTOR-1:0] el_selector(input logic [SEL_BITS-1:0] v);
    return {ELEMENT_ID_SELECTOR, LI_SELECTOR, v};
  endfunction : el_selector

  // ==========================================================
  // transmit side
  logic [FRAME_BITS-1:0] tx_sh_r;
  logic [4:0]            tx_cnt_r;
  logic                  tx_vld_r;
  logic                  tx_last_r;
  logic [RESP_BITS-1:0]  exp_r;
  logic                  pend_r;

  wire req_take   = i_req_go & ~tx_vld_r & ~pend_r;
  wire reply_take = i_reply_go & ~tx_vld_r & ~i_req_go;
  wire tx_load    = req_take | reply_take;
  wire tx_shift   = tx_vld_r & i_tx_ready;

  wire [FRAME_BITS-1:0] fr_req_fixed = {MT_REQUEST, el_seed(i_seed), el_challenge(i_challenge),
                                        el_selector(i_selector)};
  wire [FRAME_BITS-1:0] fr_req_port  = {MT_REQUEST, el_challenge(i_challenge), el_selector(i_selector),
                                        80'h0};
  wire [FRAME_BITS-1:0] fr_req_ka    = {MT_REQUEST, el_challenge(i_challenge), el_selector(i_selector),
                                        el_response(i_own_answer), 32'h0};
  wire [FRAME_BITS-1:0] fr_rep_port  = {MT_REPLY, el_response(i_own_answer), 152'h0};
  wire [FRAME_BITS-1:0] fr_rep_fixed = {MT_REPLY, el_seed(i_seed), el_response(i_own_answer),
                                        72'h0};

  wire [FRAME_BITS-1:0] fr_req  = i_role_fixed ? fr_req_fixed : (i_key_alloc ? fr_req_ka : fr_req_port);
  wire [4:0]            len_req = i_role_fixed ? FRM_REQ_FIXED
                                               : (i_key_alloc ? FRM_REQ_PORT_KA : FRM_REQ_PORT);
  wire [FRAME_BITS-1:0] fr_rep  = i_role_fixed ? fr_rep_fixed : fr_rep_port;
  wire [4:0]            len_rep = i_role_fixed ? FRM_REP_FIXED : FRM_REP_PORT;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      tx_sh_r   <= '0;
      tx_cnt_r  <= 5'h00;
      tx_vld_r  <= 1'b0;
      tx_last_r <= 1'b0;
    end else if (tx_load) begin
      tx_sh_r   <= req_take ? fr_req : fr_rep;
      tx_cnt_r  <= req_take ? len_req : len_rep;
      tx_vld_r  <= 1'b1;
      tx_last_r <= 1'b0;
    end else if (tx_shift) begin
      tx_sh_r   <= {tx_sh_r[FRAME_BITS-9:0], 8'h00};
      tx_cnt_r  <= tx_cnt_r - 5'h01;
      tx_vld_r  <= (tx_cnt_r != 5'h01);
      tx_last_r <= (tx_cnt_r == 5'h02);
    end
  end

  assign o_tx_valid = tx_vld_r;
  assign o_tx_data  = tx_sh_r[FRAME_BITS-1 -: 8];
  assign o_tx_last  = tx_last_r;

  // ==========================================================
  // receive capture into the message store
  logic [AW:0] wr_addr_r;
  logic [AW:0] msg_len_r;
  logic        rx_rdy_r;
  logic [AW:0] rd_addr_r;
  logic        rd_vld_r;
  logic [7:0]  mem_rdata;

  wire rx_acc = i_rx_valid & rx_rdy_r;
  wire wr_ok  = rx_acc & (wr_addr_r < DEPTH_CNT);
  wire rx_end = rx_acc & i_rx_last;

  ame_msg_mem #(
    .DATA_W (8),
    .DEPTH  (MEM_DEPTH),
    .AW     (AW)
  ) u_mem (
    .i_clk_sys (i_clk_sys),
    .i_we      (wr_ok),
    .i_waddr   (wr_addr_r[AW-1:0]),
    .i_wdata   (i_rx_data),
    .i_raddr   (rd_addr_r[AW-1:0]),
    .o_rdata   (mem_rdata)
  );

  // ==========================================================
  // parser
  ame_pstate_type ps_r;
  ame_pstate_type ps_nxt;
  logic [7:0]           type_r;
  logic [7:0]           id_r;
  logic [7:0]           remain_r;
  logic [CHAL_BITS-1:0] chal_acc_r;
  logic [SEED_BITS-1:0] seed_acc_r;
  logic [RESP_BITS-1:0] ans_acc_r;
  logic [SEL_BITS-1:0]  sel_acc_r;
  logic                 seen_chal_r;
  logic                 seen_seed_r;
  logic                 seen_resp_r;
  logic                 seen_sel_r;

  wire parsing   = (ps_r == PS_TYPE) | (ps_r == PS_ID) | (ps_r == PS_LEN) | (ps_r == PS_BODY);
  wire rd_issue  = parsing & (rd_addr_r < msg_len_r);
  wire read_done = parsing & (rd_addr_r == msg_len_r) & ~rd_vld_r;
  wire body_byte = rd_vld_r & (ps_r == PS_BODY);
  wire cap_chal  = body_byte & (id_r == ELEMENT_ID_CHALLENGE);
  wire cap_seed  = body_byte & (id_r == ELEMENT_ID_SEED);
  wire cap_resp  = body_byte & (id_r == ELEMENT_ID_RESPONSE);
  wire cap_sel   = body_byte & (id_r == ELEMENT_ID_SELECTOR);
  wire known_id  = cap_chal | cap_seed | cap_resp | cap_sel;

  always_comb begin
    ps_nxt = ps_r;
    unique case (ps_r)
      PS_IDLE: begin
        if (rx_end) ps_nxt = PS_TYPE;
      end
      PS_TYPE: begin
        if (read_done) ps_nxt = PS_EVAL;
        else if (rd_vld_r) ps_nxt = PS_ID;
      end
      PS_ID: begin
        if (read_done) ps_nxt = PS_EVAL;
        else if (rd_vld_r) ps_nxt = PS_LEN;
      end
      PS_LEN: begin
        if (read_done) ps_nxt = PS_EVAL;
        else if (rd_vld_r) ps_nxt = (mem_rdata == 8'h00) ? PS_ID : PS_BODY;
      end
      PS_BODY: begin
        if (read_done) ps_nxt = PS_EVAL;
        else if (rd_vld_r && remain_r == 8'h01) ps_nxt = PS_ID;
      end
      PS_EVAL: ps_nxt = PS_IDLE;
      default: ps_nxt = PS_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      ps_r      <= PS_IDLE;
      wr_addr_r <= '0;
      msg_len_r <= '0;
      rx_rdy_r  <= 1'b0;
      rd_addr_r <= '0;
      rd_vld_r  <= 1'b0;
    end else begin
      ps_r      <= ps_nxt;
      rd_vld_r  <= rd_issue;
      rx_rdy_r  <= (ps_nxt == PS_IDLE);
      wr_addr_r <= rx_end ? '0 : (wr_ok ? wr_addr_r + ONE_CNT : wr_addr_r);
      msg_len_r <= rx_end ? wr_addr_r + (wr_ok ? ONE_CNT : '0) : msg_len_r;
      rd_addr_r <= rx_end ? '0 : (rd_issue ? rd_addr_r + ONE_CNT : rd_addr_r);
    end
  end

  // fields arrive msb first, so shifting in from the right puts bit 1 of the last octet at bit 0
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn || rx_end) begin
      type_r      <= 8'h00;
      id_r        <= 8'h00;
      remain_r    <= 8'h00;
      chal_acc_r  <= '0;
      seed_acc_r  <= '0;
      ans_acc_r   <= '0;
      sel_acc_r   <= '0;
      seen_chal_r <= 1'b0;
      seen_seed_r <= 1'b0;
      seen_resp_r <= 1'b0;
      seen_sel_r  <= 1'b0;
    end else begin
      if (rd_vld_r && ps_r == PS_TYPE) type_r <= mem_rdata;
      if (rd_vld_r && ps_r == PS_ID) id_r <= mem_rdata;
      if (rd_vld_r && ps_r == PS_LEN) remain_r <= mem_rdata;
      if (body_byte) remain_r <= remain_r - 8'h01;
      if (cap_chal) chal_acc_r <= {chal_acc_r[CHAL_BITS-9:0], mem_rdata};
      if (cap_seed) seed_acc_r <= {seed_acc_r[SEED_BITS-9:0], mem_rdata};
      if (cap_resp) ans_acc_r <= {ans_acc_r[RESP_BITS-9:0], mem_rdata};
      if (cap_sel) sel_acc_r <= {sel_acc_r[SEL_BITS-9:0], mem_rdata};
      seen_chal_r <= seen_chal_r | cap_chal;
      seen_seed_r <= seen_seed_r | cap_seed;
      seen_resp_r <= seen_resp_r | cap_resp;
      seen_sel_r  <= seen_sel_r | cap_sel;
    end
  end

  // ==========================================================
  // outcome of a parsed message
  wire in_eval   = (ps_r == PS_EVAL);
  wire is_req    = (type_r == MT_REQUEST);
  wire is_rep    = (type_r == MT_REPLY);
  wire req_ok    = is_req & seen_chal_r & seen_sel_r & (i_role_fixed | seen_seed_r);
  wire rep_elems = seen_resp_r & (i_role_fixed | seen_seed_r);
  wire ans_match = rep_elems & (ans_acc_r == exp_r);
  wire rep_eval  = in_eval & is_rep & pend_r;
  logic req_rcvd_r;
  logic ka_r;
  logic pass_r;
  logic drop_r;
  logic err_r;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      exp_r      <= '0;
      pend_r     <= 1'b0;
      req_rcvd_r <= 1'b0;
      ka_r       <= 1'b0;
      pass_r     <= 1'b0;
      drop_r     <= 1'b0;
      err_r      <= 1'b0;
    end else begin
      if (req_take) exp_r <= i_expected;
      pend_r     <= req_take | (pend_r & ~rep_eval);
      req_rcvd_r <= in_eval & req_ok;
      if (in_eval && req_ok) ka_r <= ~i_role_fixed ? 1'b0 : seen_resp_r;
      pass_r     <= rep_eval & ans_match;
      drop_r     <= rep_eval & ~ans_match;
      err_r      <= in_eval & ~req_ok & ~(is_rep & pend_r);
    end
  end

  assign o_rx_ready     = rx_rdy_r;
  assign o_req_rcvd     = req_rcvd_r;
  assign o_rx_key_alloc = ka_r;
  assign o_rx_challenge = chal_acc_r;
  assign o_rx_seed      = seed_acc_r;
  assign o_rx_answer    = ans_acc_r;
  assign o_rx_selector  = sel_acc_r;
  assign o_auth_pass    = pass_r;
  assign o_call_drop    = drop_r;
  assign o_msg_err      = err_r;
  assign o_auth_pending = pend_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);

  sequence s_load_req;
    req_take ##1 o_tx_valid;
  endsequence

  sequence s_reply_checked;
    rep_eval ##1 (o_auth_pass || o_call_drop);
  endsequence

  property p_req_type;
    s_load_req |-> o_tx_data == MT_REQUEST && !o_tx_data[7];
  endproperty
  a_req_type: assert property (p_req_type) else $error("request type octet wrong");

  property p_rep_type;
    reply_take |=> o_tx_valid && o_tx_data == MT_REPLY;
  endproperty
  a_rep_type: assert property (p_rep_type) else $error("reply type octet wrong");

  property p_fixed_req;
    req_take && i_role_fixed |=> tx_sh_r[FRAME_BITS-9 -: 16] == {ELEMENT_ID_SEED, LI_SEED}
      && tx_cnt_r == FRM_REQ_FIXED;
  endproperty
  a_fixed_req: assert property (p_fixed_req) else $error("fixed request layout wrong");

  property p_port_req;
    req_take && !i_role_fixed |=> tx_sh_r[FRAME_BITS-9 -: 16] == {ELEMENT_ID_CHALLENGE, LI_CHALLENGE}
      && tx_cnt_r == ($past(i_key_alloc) ? FRM_REQ_PORT_KA : FRM_REQ_PORT);
  endproperty
  a_port_req: assert property (p_port_req) else $error("portable request layout wrong");

  property p_drop;
    rep_eval && !ans_match |=> o_call_drop && !o_auth_pass ##1 !o_auth_pending;
  endproperty
  a_drop: assert property (p_drop) else $error("mismatch did not drop call");

  property p_pass;
    s_reply_checked |-> o_auth_pass == $past(ans_match) && !o_auth_pending;
  endproperty
  a_pass: assert property (p_pass) else $error("reply verdict wrong");

  property p_skip;
    body_byte && !known_id |=> $stable(chal_acc_r) && $stable(ans_acc_r) && $stable(seed_acc_r);
  endproperty
  a_skip: assert property (p_skip) else $error("unknown element altered fields");

  property p_parse_ends;
    ps_r == PS_TYPE && $past(ps_r) == PS_IDLE |-> ##[1:PARSE_BOUND] ps_r == PS_EVAL;
  endproperty
  a_parse_ends: assert property (p_parse_ends) else $error("parse did not finish");

  property p_last;
    o_tx_last |-> o_tx_valid && tx_cnt_r == 5'h01;
  endproperty
  a_last: assert property (p_last) else $error("last flag misplaced");

endmodule : ame_framer

`default_nettype wire

// file: ame_peer.sv
// peer terminal model: takes framed octets from the block and feeds octet streams back to it
`timescale 1ns/1ps
`default_nettype none

module ame_peer (
  input  wire logic       i_clk_sys,
  input  wire logic       i_stall,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  input  wire logic       i_tx_last,
  output logic            o_tx_ready,
  output logic            o_rx_valid,
  output logic      [7:0] o_rx_data,
  output logic            o_rx_last,
  input  wire logic       i_rx_ready
);
  logic [7:0] cap[$];
  int         last_idx;

  // ==========================================================
  // capture side, stalls on request of the bench
  assign o_tx_ready = !i_stall;

  initial begin
    o_rx_valid = 1'b0;
    o_rx_data  = 8'hA5;
    o_rx_last  = 1'b0;
    last_idx   = -1;
  end

  always @(posedge i_clk_sys) begin
    if (i_tx_valid && o_tx_ready) begin
      cap.push_back(i_tx_data);
      if (i_tx_last) begin
        last_idx = cap.size() - 1;
      end
    end
  end

  // ==========================================================
  // send side: each octet held until taken with ready high, or for at most 200 cycles, which clears ok
  task automatic send(input logic [7:0] q[$], output bit ok);
    int n;
    ok = 1'b1;
    foreach (q[k]) begin
      @(negedge i_clk_sys);
      o_rx_valid = 1'b1;
      o_rx_data  = q[k];
      o_rx_last  = (k == q.size() - 1);
      n = 0;
      do begin
        @(posedge i_clk_sys);
        n++;
      end while (!i_rx_ready && n < 200);
      if (!i_rx_ready) begin
        ok = 1'b0;
      end
    end
    @(negedge i_clk_sys);
    o_rx_valid = 1'b0;
    o_rx_last  = 1'b0;
    // released line shows the inverse, so a stale octet is never mistaken for data
    o_rx_data  = ~o_rx_data;
  endtask : send
endmodule : ame_peer

`default_nettype wire

// file: ame_tb.sv
// self-checking bench for the authentication framer
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic        clk, rstn, role_fixed, req_go, reply_go, key_alloc, stall;
  logic [63:0] challenge, seed, rx_challenge, rx_seed;
  logic [23:0] selector, rx_selector;
  logic [31:0] expected, own_answer, rx_answer;
  logic [31:0] rnd_state = 32'h00007BF5;
  logic        tx_ready, tx_valid, tx_last, rx_valid, rx_last, rx_ready;
  logic [7:0]  tx_data, rx_data;
  logic        req_rcvd, rx_key_alloc, auth_pass, call_drop, msg_err, auth_pending;
  logic [7:0]  q_exp[$];
  int          failures, num_checks;

  ame_framer #(.MEM_DEPTH(32)) dut (
    .i_clk_sys(clk), .i_rstn(rstn), .i_role_fixed(role_fixed), .i_req_go(req_go),
    .i_reply_go(reply_go), .i_key_alloc(key_alloc), .i_challenge(challenge), .i_seed(seed),
    .i_selector(selector), .i_expected(expected), .i_own_answer(own_answer), .i_tx_ready(tx_ready),
    .o_tx_valid(tx_valid), .o_tx_data(tx_data), .o_tx_last(tx_last), .i_rx_valid(rx_valid),
    .i_rx_data(rx_data), .i_rx_last(rx_last), .o_rx_ready(rx_ready), .o_req_rcvd(req_rcvd),
    .o_rx_key_alloc(rx_key_alloc), .o_rx_challenge(rx_challenge), .o_rx_seed(rx_seed),
    .o_rx_answer(rx_answer), .o_rx_selector(rx_selector), .o_auth_pass(auth_pass),
    .o_call_drop(call_drop), .o_msg_err(msg_err), .o_auth_pending(auth_pending));

  ame_peer peer (
    .i_clk_sys(clk), .i_stall(stall), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
    .i_tx_last(tx_last), .o_tx_ready(tx_ready), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
    .o_rx_last(rx_last), .i_rx_ready(rx_ready));

  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    rnd_state = rnd_state ^ (rnd_state << 13);
    rnd_state = rnd_state ^ (rnd_state >> 17);
    rnd_state = rnd_state ^ (rnd_state << 5);
    return rnd_state;
  endfunction : rnd

  task automatic stop_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s at %0t: got %h exp %h", what, $time, got, exp);
    end
  endtask : chk

  // element: identifier, content length, content msb first
  task automatic put(input logic [7:0] id, input int n, input logic [63:0] v);
    q_exp.push_back(id);
    q_exp.push_back(8'(n));
    for (int k = n - 1; k >= 0; k--) q_exp.push_back(v[k*8 +: 8]);
  endtask : put

  task automatic pulse(input bit rep);
    peer.cap.delete();
    peer.last_idx = -1;
    @(negedge clk);
    if (rep) reply_go = 1'b1;
    else req_go = 1'b1;
    @(negedge clk);
    req_go   = 1'b0;
    reply_go = 1'b0;
  endtask : pulse

  task automatic chk_frame();
    int n;
    n = 0;
    while (peer.last_idx < 0 && n < 400) begin
      @(negedge clk);
      n++;
    end
    if (peer.last_idx < 0) begin
      failures++;
      stop_test();
    end
    chk("length", 64'(peer.cap.size()), 64'(q_exp.size()));
    chk("last", 64'(peer.last_idx), 64'(q_exp.size() - 1));
    foreach (q_exp[k]) chk("octet", peer.cap[k], q_exp[k]);
    chk("valid after last", tx_valid, 1'b0);
  endtask : chk_frame

  task automatic feed_and_wait(input logic [3:0] exp);
    logic [3:0] r;
    bit         ok;
    int         n;
    peer.send(q_exp, ok);
    chk("accepted", ok, 1'b1);
    r = 4'h0;
    n = 0;
    while (r == 4'h0 && n < 300) begin
      @(negedge clk);
      r = {req_rcvd, auth_pass, call_drop, msg_err};
      n++;
    end
    if (r === 4'h0) begin
      failures++;
      stop_test();
    end
    chk("result", r, exp);
  endtask : feed_and_wait

  // own request, then the peer's reply, matching or with one bit flipped
  task automatic run_auth(input bit fixed, input bit ka, input bit good);
    role_fixed = fixed;
    key_alloc  = ka;
    challenge  = {rnd(), rnd()};
    seed       = {rnd(), rnd()};
    selector   = 24'(rnd());
    expected   = rnd();
    own_answer = rnd();
    pulse(1'b0);
    q_exp = {8'h40};
    if (fixed) put(8'h0E, 8, seed);
    put(8'h0C, 8, challenge);
    put(8'h0A, 3, selector);
    if (!fixed && ka) put(8'h0D, 4, 64'(own_answer));
    chk_frame();
    chk("pending", auth_pending, 1'b1);
    q_exp = {8'h41};
    if (!fixed) put(8'h0E, 8, seed);
    put(8'h0D, 4, 64'(good ? expected : expected ^ (fixed ? 32'h00000001 : 32'h80000000)));
    feed_and_wait(good ? 4'h4 : 4'h2);
    chk("pending cleared", auth_pending, 1'b0);
  endtask : run_auth

  // ==========================================================
  // clock, stall pattern and main sequence
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(negedge clk) stall <= (rnd() % 4) == 0;

  initial begin
    {rstn, role_fixed, req_go, reply_go, key_alloc} = 5'h00;
    {challenge, seed, selector, expected, own_answer} = '0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    chk("ready after reset", rx_ready, 1'b1);
    chk("idle after reset", tx_valid, 1'b0);
    for (int i = 0; i < 8; i++) run_auth(i % 2 == 0, i[1], i < 2 || i > 3);
    for (int i = 0; i < 2; i++) begin
      role_fixed = i[0];
      seed       = {rnd(), rnd()};
      own_answer = rnd();
      pulse(1'b1);
      q_exp = {8'h41};
      if (i == 1) put(8'h0E, 8, seed);
      put(8'h0D, 4, 64'(own_answer));
      chk_frame();
    end
    // fixed end parses a key-allocation request padded with foreign elements
    role_fixed = 1'b1;
    challenge  = {rnd(), rnd()};
    selector   = 24'(rnd());
    own_answer = rnd();
    q_exp = {8'h40};
    put(8'h0C, 8, challenge);
    put(8'h7B, 2, 64'h00000000_0000BEEF);
    put(8'h3C, 0, 64'h0);
    put(8'h0A, 3, selector);
    put(8'h0D, 4, 64'(own_answer));
    feed_and_wait(4'h8);
    chk("rx challenge", rx_challenge, challenge);
    chk("rx selector", rx_selector, selector);
    chk("rx key alloc", rx_key_alloc, 1'b1);
    chk("rx answer", rx_answer, own_answer);
    // portable end parses a fixed request
    role_fixed = 1'b0;
    seed       = {rnd(), rnd()};
    q_exp = {8'h40};
    put(8'h0E, 8, seed);
    put(8'h0C, 8, challenge);
    put(8'h0A, 3, selector);
    feed_and_wait(4'h8);
    chk("rx seed", rx_seed, seed);
    chk("rx key alloc", rx_key_alloc, 1'b0);
    chk("rx answer", rx_answer, 64'h0);
    // a reply with nothing pending is refused
    q_exp = {8'h41};
    put(8'h0D, 4, 64'(own_answer));
    feed_and_wait(4'h1);
    stop_test();
  end
endmodule : tb

`default_nettype wire
